/* pkg/drive_param_pkg.sv */
// drive_param_pkg: addresses, limits, codes and reset values of the drive parameter
// holding registers. assumes 16-bit register words on a plain strobe port.
package drive_param_pkg;

  // word addresses of the holding registers
  localparam logic [15:0] ADDR_ACCEL_HI    = 16'h1014;
  localparam logic [15:0] ADDR_ACCEL_LO    = 16'h1015;
  localparam logic [15:0] ADDR_DECEL_HI    = 16'h1016;
  localparam logic [15:0] ADDR_DECEL_LO    = 16'h1017;
  localparam logic [15:0] ADDR_RUN_DIR     = 16'h1018;
  localparam logic [15:0] ADDR_FREQ_SRC    = 16'h1019;
  localparam logic [15:0] ADDR_RUN_SRC     = 16'h101A;
  localparam logic [15:0] ADDR_BASE_FREQ   = 16'h101B;
  localparam logic [15:0] ADDR_MAX_FREQ    = 16'h101C;
  localparam logic [15:0] ADDR_AI_SEL      = 16'h101D;
  localparam logic [15:0] ADDR_AI_ST_FREQ  = 16'h1020;
  localparam logic [15:0] ADDR_AI_END_FREQ = 16'h1022;
  localparam logic [15:0] ADDR_AI_ST_PT    = 16'h1023;
  localparam logic [15:0] ADDR_AI_END_PT   = 16'h1024;
  localparam logic [15:0] ADDR_AI_ST_BEH   = 16'h1025;
  localparam logic [15:0] ADDR_FILT_N      = 16'h1026;
  localparam logic [15:0] ADDR_ACCEL2_HI   = 16'h1501;
  localparam logic [15:0] ADDR_ACCEL2_LO   = 16'h1502;
  localparam logic [15:0] ADDR_DECEL2_HI   = 16'h1503;
  localparam logic [15:0] ADDR_DECEL2_LO   = 16'h1504;
  localparam logic [15:0] ADDR_BASE_FREQ2  = 16'h150C;
  localparam logic [15:0] ADDR_MAX_FREQ2   = 16'h150D;

  // ramp time slots: 0 accel, 1 decel, 2 accel motor 2, 3 decel motor 2
  localparam int RAMP_SLOTS = 4;
  localparam logic [RAMP_SLOTS-1:0][15:0] RAMP_HI_ADDR =
    {ADDR_DECEL2_HI, ADDR_ACCEL2_HI, ADDR_DECEL_HI, ADDR_ACCEL_HI};

  // limits
  localparam logic [31:0] RAMP_MIN       = 32'h0000_0001;
  localparam logic [31:0] RAMP_MAX       = 32'h0004_93E0;
  localparam logic [31:0] RAMP_COARSE    = 32'h0000_2710;
  localparam logic [31:0] RAMP_DIGIT     = 32'h0000_000A;
  localparam logic [15:0] BASE_MIN       = 16'h001E;
  localparam logic [15:0] MAX_FREQ_TOP   = 16'h0190;
  localparam logic [15:0] AI_FREQ_TOP    = 16'h0FA0;
  localparam logic [15:0] AI_PT_TOP      = 16'h0064;
  localparam logic [15:0] FILT_N_MIN     = 16'h0001;
  localparam logic [15:0] FILT_N_AVG_TOP = 16'h0010;
  localparam logic [15:0] FILT_N_DEADBND = 16'h0011;
  localparam logic [15:0] DEADBAND_UP    = 16'h0001;
  localparam logic [15:0] DEADBAND_DN    = 16'h0002;

  // select codes
  localparam logic [15:0] DIR_FWD        = 16'h0000;
  localparam logic [15:0] DIR_REV        = 16'h0001;
  localparam logic [15:0] FSRC_POT       = 16'h0000;
  localparam logic [15:0] FSRC_NET       = 16'h0003;
  localparam logic [15:0] FSRC_CALC      = 16'h000A;
  localparam logic [15:0] RSRC_TERM      = 16'h0001;
  localparam logic [15:0] RSRC_NET       = 16'h0003;
  localparam logic [15:0] AI_SEL_TERM    = 16'h0000;
  localparam logic [15:0] AI_SEL_V_POT   = 16'h0002;
  localparam logic [15:0] AI_SEL_I_ONLY  = 16'h0005;
  localparam logic [15:0] BEH_OFFSET     = 16'h0000;
  localparam logic [15:0] BEH_ZERO       = 16'h0001;

  // reset values
  localparam logic [31:0] RST_RAMP       = 32'h0000_03E8;
  localparam logic [15:0] RST_FREQ_SRC   = 16'h0000;
  localparam logic [15:0] RST_RUN_SRC    = 16'h0002;
  localparam logic [15:0] RST_BASE       = 16'h0032;
  localparam logic [15:0] RST_MAX        = 16'h0032;
  localparam logic [15:0] RST_AI_END_PT  = 16'h0064;
  localparam logic [15:0] RST_FILT_N     = 16'h0008;
  localparam logic [15:0] ZERO16         = 16'h0000;

  typedef struct packed {
    logic [RAMP_SLOTS-1:0][31:0] ramp_time;
    logic [15:0] run_dir;
    logic [15:0] freq_src;
    logic [15:0] run_src;
    logic [15:0] base_freq;
    logic [15:0] max_freq;
    logic [15:0] ai_sel;
    logic [15:0] ai_start_freq;
    logic [15:0] ai_end_freq;
    logic [15:0] ai_start_pt;
    logic [15:0] ai_end_pt;
    logic [15:0] ai_start_beh;
    logic [15:0] filt_n;
    logic [15:0] base_freq_m2;
    logic [15:0] max_freq_m2;
  } param_s;

  localparam param_s PARAM_RESET = '{
    ramp_time:     {RAMP_SLOTS{RST_RAMP}},
    run_dir:       DIR_FWD,
    freq_src:      RST_FREQ_SRC,
    run_src:       RST_RUN_SRC,
    base_freq:     RST_BASE,
    max_freq:      RST_MAX,
    ai_sel:        AI_SEL_TERM,
    ai_start_freq: ZERO16,
    ai_end_freq:   ZERO16,
    ai_start_pt:   ZERO16,
    ai_end_pt:     RST_AI_END_PT,
    ai_start_beh:  BEH_OFFSET,
    filt_n:        RST_FILT_N,
    base_freq_m2:  RST_BASE,
    max_freq_m2:   RST_MAX
  };

endpackage

/* rtl/drive_parameter_holding_regs.sv */
// drive_parameter_holding_regs: 16-bit holding registers of the drive parameters,
// range checked on write, plus the averaging filter of the external frequency input.
// assumes a network master issuing single-cycle read or write strobes on clk_i.
// Operation
// - motor 1 acceleration time sits at 1014h/1015h and deceleration at 1016h/1017h, 1..300000.
// - motor 2 acceleration time sits at 1501h/1502h and deceleration at 1503h/1504h, 1..300000.
// - a ramp time of 10000 or more has its hundredths digit dropped where it is used.
// - the run direction at 1018h is 0 forward or 1 reverse.
// - the frequency source at 1019h takes codes 0 to 3 and 10 only.
// - the run command source at 101Ah takes codes 1, 2 and 3 only.
// - motor 1 base frequency at 101Bh lies from 30 Hz up to motor 1 maximum frequency.
// - motor 2 base frequency at 150Ch lies from 30 Hz up to motor 2 maximum frequency.
// - maximum frequencies at 101Ch and 150Dh lie from their base frequency up to 400 Hz.
// - the analog selection at 101Dh takes codes 0, 2, 3, 4 and 5 only.
// - analog range start and end frequencies at 1020h and 1022h lie in 0..4000.
// - analog range start and end points at 1023h and 1024h lie in 0..100.
// - the analog start behaviour at 1025h is 0 use offset or 1 use 0 Hz.
// - the external frequency is averaged over n samples, n from 1 to 16 at 1026h.
// - a filter setting of 17 averages 16 samples and adds a +0.1/-0.2 Hz deadband.
`timescale 1ns/10ps
`default_nettype none

module drive_parameter_holding_regs #(
  parameter int FREQ_W = 16
) (
  input  wire logic                                           clk_i,
  input  wire logic                                           reset_n_i,
  input  wire logic                                           clk_en_i,
  input  wire logic                                           reg_wr_i,
  input  wire logic                                           reg_rd_i,
  input  wire logic [15:0]                                    reg_addr_i,
  input  wire logic [15:0]                                    reg_wdata_i,
  output logic      [15:0]                                    reg_rdata_o,
  output logic                                                reg_ack_o,
  output logic                                                reg_err_o,
  input  wire logic                                           ext_freq_valid_i,
  input  wire logic [FREQ_W-1:0]                              ext_freq_i,
  output logic      [FREQ_W-1:0]                              ext_freq_filt_o,
  output drive_param_pkg::param_s                             params_o,
  output logic      [drive_param_pkg::RAMP_SLOTS-1:0][31:0]   ramp_time_eff_o
);

  localparam int NSAMP = 16;
  localparam int SUM_W = FREQ_W + 5;
  localparam int EXT_W = FREQ_W + 4;

  initial begin
    if (FREQ_W < 4 || FREQ_W > 24) begin
      $error("FREQ_W out of supported range");
    end
  end

  // ---------------- register file ----------------
  drive_param_pkg::param_s regs_r;
  drive_param_pkg::param_s regs_nxt;
  logic [15:0]             hi_stage_r;
  logic [15:0]             hi_stage_nxt;
  logic [15:0]             hi_addr_r;
  logic [15:0]             hi_addr_nxt;
  logic                    hi_valid_r;
  logic                    hi_valid_nxt;
  logic [15:0]             rdata_nxt;
  logic                    ack_nxt;
  logic                    err_nxt;

  // true when a 16-bit code is one of the listed select codes
  function automatic logic in_set_fsrc(input logic [15:0] v);
    in_set_fsrc = (v <= drive_param_pkg::FSRC_NET) || (v == drive_param_pkg::FSRC_CALC);
  endfunction

  function automatic logic in_set_aisel(input logic [15:0] v);
    in_set_aisel = (v == drive_param_pkg::AI_SEL_TERM) ||
                   ((v >= drive_param_pkg::AI_SEL_V_POT) &&
                    (v <= drive_param_pkg::AI_SEL_I_ONLY));
  endfunction

  always_comb begin
    logic [31:0] cand;
    logic        mapped;
    logic        ok;
    logic        hit;
    cand         = '0;
    mapped       = 1'b0;
    ok           = 1'b0;
    hit          = 1'b0;
    regs_nxt     = regs_r;
    hi_stage_nxt = hi_stage_r;
    hi_addr_nxt  = hi_addr_r;
    hi_valid_nxt = hi_valid_r;
    rdata_nxt    = reg_rdata_o;
    ack_nxt      = 1'b0;
    err_nxt      = 1'b0;
    if (reg_wr_i) begin
      ack_nxt = 1'b1;
      for (int s = 0; s < drive_param_pkg::RAMP_SLOTS; s++) begin
        if (reg_addr_i == drive_param_pkg::RAMP_HI_ADDR[s]) begin
          // high word waits for its low word so the pair is checked as one value
          hit          = 1'b1;
          hi_stage_nxt = reg_wdata_i;
          hi_addr_nxt  = reg_addr_i;
          hi_valid_nxt = 1'b1;
        end else if (reg_addr_i == drive_param_pkg::RAMP_HI_ADDR[s] + 16'h0001) begin
          hit = 1'b1;
          if (hi_valid_r && hi_addr_r == drive_param_pkg::RAMP_HI_ADDR[s]) begin
            cand = {hi_stage_r, reg_wdata_i};
          end else begin
            cand = {regs_r.ramp_time[s][31:16], reg_wdata_i};
          end
          hi_valid_nxt = 1'b0;
          if (cand >= drive_param_pkg::RAMP_MIN && cand <= drive_param_pkg::RAMP_MAX) begin
            regs_nxt.ramp_time[s] = cand;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      if (!hit) begin
        mapped = 1'b1;
        if (reg_addr_i == drive_param_pkg::ADDR_RUN_DIR) begin
          ok = reg_wdata_i <= drive_param_pkg::DIR_REV;
          if (ok) regs_nxt.run_dir = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_FREQ_SRC) begin
          ok = in_set_fsrc(reg_wdata_i);
          if (ok) regs_nxt.freq_src = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_RUN_SRC) begin
          ok = reg_wdata_i >= drive_param_pkg::RSRC_TERM &&
               reg_wdata_i <= drive_param_pkg::RSRC_NET;
          if (ok) regs_nxt.run_src = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_BASE_FREQ) begin
          ok = reg_wdata_i >= drive_param_pkg::BASE_MIN &&
               reg_wdata_i <= regs_r.max_freq;
          if (ok) regs_nxt.base_freq = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_MAX_FREQ) begin
          ok = reg_wdata_i >= regs_r.base_freq &&
               reg_wdata_i <= drive_param_pkg::MAX_FREQ_TOP;
          if (ok) regs_nxt.max_freq = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_SEL) begin
          ok = in_set_aisel(reg_wdata_i);
          if (ok) regs_nxt.ai_sel = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_FREQ) begin
          ok = reg_wdata_i <= drive_param_pkg::AI_FREQ_TOP;
          if (ok) regs_nxt.ai_start_freq = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_END_FREQ) begin
          ok = reg_wdata_i <= drive_param_pkg::AI_FREQ_TOP;
          if (ok) regs_nxt.ai_end_freq = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_PT) begin
          ok = reg_wdata_i <= drive_param_pkg::AI_PT_TOP;
          if (ok) regs_nxt.ai_start_pt = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_END_PT) begin
          ok = reg_wdata_i <= drive_param_pkg::AI_PT_TOP;
          if (ok) regs_nxt.ai_end_pt = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_BEH) begin
          ok = reg_wdata_i <= drive_param_pkg::BEH_ZERO;
          if (ok) regs_nxt.ai_start_beh = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_FILT_N) begin
          ok = reg_wdata_i >= drive_param_pkg::FILT_N_MIN &&
               reg_wdata_i <= drive_param_pkg::FILT_N_DEADBND;
          if (ok) regs_nxt.filt_n = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_BASE_FREQ2) begin
          ok = reg_wdata_i >= drive_param_pkg::BASE_MIN &&
               reg_wdata_i <= regs_r.max_freq_m2;
          if (ok) regs_nxt.base_freq_m2 = reg_wdata_i;
        end else if (reg_addr_i == drive_param_pkg::ADDR_MAX_FREQ2) begin
          ok = reg_wdata_i >= regs_r.base_freq_m2 &&
               reg_wdata_i <= drive_param_pkg::MAX_FREQ_TOP;
          if (ok) regs_nxt.max_freq_m2 = reg_wdata_i;
        end else begin
          mapped = 1'b0;
        end
        err_nxt = !mapped || !ok;
      end
    end else if (reg_rd_i) begin
      ack_nxt   = 1'b1;
      rdata_nxt = '0;
      for (int s = 0; s < drive_param_pkg::RAMP_SLOTS; s++) begin
        if (reg_addr_i == drive_param_pkg::RAMP_HI_ADDR[s]) begin
          hit       = 1'b1;
          rdata_nxt = regs_r.ramp_time[s][31:16];
        end else if (reg_addr_i == drive_param_pkg::RAMP_HI_ADDR[s] + 16'h0001) begin
          hit       = 1'b1;
          rdata_nxt = regs_r.ramp_time[s][15:0];
        end
      end
      if (!hit) begin
        if (reg_addr_i == drive_param_pkg::ADDR_RUN_DIR) begin
          rdata_nxt = regs_r.run_dir;
        end else if (reg_addr_i == drive_param_pkg::ADDR_FREQ_SRC) begin
          rdata_nxt = regs_r.freq_src;
        end else if (reg_addr_i == drive_param_pkg::ADDR_RUN_SRC) begin
          rdata_nxt = regs_r.run_src;
        end else if (reg_addr_i == drive_param_pkg::ADDR_BASE_FREQ) begin
          rdata_nxt = regs_r.base_freq;
        end else if (reg_addr_i == drive_param_pkg::ADDR_MAX_FREQ) begin
          rdata_nxt = regs_r.max_freq;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_SEL) begin
          rdata_nxt = regs_r.ai_sel;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_FREQ) begin
          rdata_nxt = regs_r.ai_start_freq;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_END_FREQ) begin
          rdata_nxt = regs_r.ai_end_freq;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_PT) begin
          rdata_nxt = regs_r.ai_start_pt;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_END_PT) begin
          rdata_nxt = regs_r.ai_end_pt;
        end else if (reg_addr_i == drive_param_pkg::ADDR_AI_ST_BEH) begin
          rdata_nxt = regs_r.ai_start_beh;
        end else if (reg_addr_i == drive_param_pkg::ADDR_FILT_N) begin
          rdata_nxt = regs_r.filt_n;
        end else if (reg_addr_i == drive_param_pkg::ADDR_BASE_FREQ2) begin
          rdata_nxt = regs_r.base_freq_m2;
        end else if (reg_addr_i == drive_param_pkg::ADDR_MAX_FREQ2) begin
          rdata_nxt = regs_r.max_freq_m2;
        end else begin
          err_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regs_r      <= drive_param_pkg::PARAM_RESET;
      hi_stage_r  <= '0;
      hi_addr_r   <= '0;
      hi_valid_r  <= 1'b0;
      reg_rdata_o <= '0;
      reg_ack_o   <= 1'b0;
      reg_err_o   <= 1'b0;
    end else if (clk_en_i) begin
      regs_r      <= regs_nxt;
      hi_stage_r  <= hi_stage_nxt;
      hi_addr_r   <= hi_addr_nxt;
      hi_valid_r  <= hi_valid_nxt;
      reg_rdata_o <= rdata_nxt;
      reg_ack_o   <= ack_nxt;
      reg_err_o   <= err_nxt;
    end
  end

  assign params_o = regs_r;

  // coarse ramp times drop the hundredths digit; stored value still reads back whole
  genvar g;
  generate
    for (g = 0; g < drive_param_pkg::RAMP_SLOTS; g++) begin : g_ramp
      assign ramp_time_eff_o[g] = (regs_r.ramp_time[g] >= drive_param_pkg::RAMP_COARSE) ?
        regs_r.ramp_time[g] - (regs_r.ramp_time[g] % drive_param_pkg::RAMP_DIGIT) :
        regs_r.ramp_time[g];
    end
  endgenerate

  // ---------------- external frequency filter ----------------
  logic [NSAMP-1:0][FREQ_W-1:0] samp_r;
  logic [NSAMP-1:0][FREQ_W-1:0] samp_nxt;
  logic [3:0]                   wr_idx_r;
  logic [3:0]                   wr_idx_nxt;
  logic [4:0]                   fill_r;
  logic [4:0]                   fill_nxt;
  logic [FREQ_W-1:0]            filt_r;
  logic [FREQ_W-1:0]            filt_nxt;
  logic [NSAMP-1:0][FREQ_W-1:0] term;
  logic [4:0]                   n_req;
  logic [4:0]                   n_use;
  logic [SUM_W-1:0]             sum;
  logic [FREQ_W-1:0]            avg;

  assign n_req = (regs_r.filt_n >= drive_param_pkg::FILT_N_AVG_TOP) ?
                 5'(drive_param_pkg::FILT_N_AVG_TOP) : 5'(regs_r.filt_n);

  // new sample included: window covers the last n_use entries ending at wr_idx_r
  assign n_use = (fill_r < n_req) ? fill_r + 5'd1 : n_req;

  generate
    for (g = 0; g < NSAMP; g++) begin : g_win
      logic [3:0] age;
      logic [FREQ_W-1:0] val;
      assign age = wr_idx_r - 4'(g);
      assign val = (4'(g) == wr_idx_r) ? ext_freq_i : samp_r[g];
      assign term[g] = ({1'b0, age} < n_use) ? val : '0;
    end
  endgenerate

  always_comb begin
    sum = '0;
    for (int i = 0; i < NSAMP; i++) begin
      sum = sum + SUM_W'(term[i]);
    end
  end

  assign avg = FREQ_W'(sum / SUM_W'(n_use));

  always_comb begin
    samp_nxt   = samp_r;
    wr_idx_nxt = wr_idx_r;
    fill_nxt   = fill_r;
    filt_nxt   = filt_r;
    if (ext_freq_valid_i) begin
      samp_nxt[wr_idx_r] = ext_freq_i;
      wr_idx_nxt         = wr_idx_r + 4'd1;
      if (fill_r < 5'(NSAMP)) fill_nxt = fill_r + 5'd1;
      if (regs_r.filt_n == drive_param_pkg::FILT_N_DEADBND) begin
        // deadband holds the output against small jitter around the set point
        if ({4'd0, avg} > {4'd0, filt_r} + EXT_W'(drive_param_pkg::DEADBAND_UP) ||
            {4'd0, avg} + EXT_W'(drive_param_pkg::DEADBAND_DN) < {4'd0, filt_r}) begin
          filt_nxt = avg;
        end
      end else begin
        filt_nxt = avg;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      samp_r   <= '0;
      wr_idx_r <= '0;
      fill_r   <= '0;
      filt_r   <= '0;
    end else if (clk_en_i) begin
      samp_r   <= samp_nxt;
      wr_idx_r <= wr_idx_nxt;
      fill_r   <= fill_nxt;
      filt_r   <= filt_nxt;
    end
  end

  assign ext_freq_filt_o = filt_r;

  // ---------------- checks ----------------
  chk_ramp_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.ramp_time[0] >= drive_param_pkg::RAMP_MIN &&
    regs_r.ramp_time[1] <= drive_param_pkg::RAMP_MAX && regs_r.ramp_time[1] != 0)
    else $error("motor 1 ramp time out of range");
  chk_ramp2_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.ramp_time[2] <= drive_param_pkg::RAMP_MAX && regs_r.ramp_time[3] != 0)
    else $error("motor 2 ramp time out of range");
  chk_coarse_digit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.ramp_time[0] >= drive_param_pkg::RAMP_COARSE |->
      ramp_time_eff_o[0] % drive_param_pkg::RAMP_DIGIT == 0 &&
      regs_r.ramp_time[0] - ramp_time_eff_o[0] < drive_param_pkg::RAMP_DIGIT)
    else $error("coarse ramp time keeps hundredths");
  chk_dir_code: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && reg_wr_i && reg_addr_i == drive_param_pkg::ADDR_RUN_DIR &&
    reg_wdata_i <= drive_param_pkg::DIR_REV |=> regs_r.run_dir == $past(reg_wdata_i))
    else $error("valid direction code not stored");
  chk_src_codes: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    in_set_fsrc(regs_r.freq_src) && in_set_aisel(regs_r.ai_sel))
    else $error("illegal source code stored");
  chk_run_src: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.run_src >= drive_param_pkg::RSRC_TERM && regs_r.run_src <= drive_param_pkg::RSRC_NET)
    else $error("illegal run source stored");
  chk_base_max: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.base_freq >= drive_param_pkg::BASE_MIN && regs_r.base_freq <= regs_r.max_freq &&
    regs_r.max_freq <= drive_param_pkg::MAX_FREQ_TOP)
    else $error("motor 1 base or max frequency out of range");
  chk_base2_max2: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    regs_r.base_freq_m2 >= drive_param_pkg::BASE_MIN &&
    regs_r.base_freq_m2 <= regs_r.max_freq_m2)
    else $error("motor 2 base frequency out of range");
  chk_split_word: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && reg_wr_i && reg_addr_i == drive_param_pkg::ADDR_ACCEL_LO && !err_nxt |=>
      regs_r.ramp_time[0][15:0] == $past(reg_wdata_i))
    else $error("low word not placed in bits 15:0");
  chk_reject_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_err_o && $past(reg_wr_i) |-> regs_r == $past(regs_r))
    else $error("refused write changed a register");
  chk_filter_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && regs_r.filt_n == drive_param_pkg::FILT_N_DEADBND && ext_freq_valid_i &&
    avg == filt_r + 1 |=> $stable(filt_r))
    else $error("deadband did not hold output");

endmodule // drive_parameter_holding_regs

`default_nettype wire

/* sim/net_master.sv */
// net_master: network master model, one single-cycle register strobe per transfer.
// assumes the register port answers with ack one cycle after the strobe edge.
`timescale 1ns/10ps
`default_nettype none
module net_master (
  input  wire logic        clk_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [15:0]      addr_o,
  output logic [15:0]      data_o
);
  initial {wr_o, rd_o, addr_o, data_o} = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    {wr_o, rd_o, addr_o, data_o} = {w, !w, a, d};
    @(posedge clk_i);
    #1;
    // released bus shows the inverse so a stale value cannot pass as held
    {wr_o, rd_o, addr_o, data_o} = {2'b00, ~a, ~d};
  endtask
endmodule // net_master
`default_nettype wire

/* sim/testbench.sv */
// testbench: register and filter scenarios for the drive parameter holding registers.
// assumes net_master drives the port; expectations are queued and checked on ack.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  localparam logic [4:0][15:0] SEL_A = {16'h1019, 16'h101D, 16'h101A, 16'h1025, 16'h1018};
  localparam logic [4:0][15:0] SEL_OK = {16'h040F, 16'h003D, 16'h000E, 16'h0003, 16'h0003};
  logic                    clk_i, reset_n_i, wr, rd, ack, err, fv, en;
  logic [15:0]             addr, wd, rdata, fq, filt, rnd;
  drive_param_pkg::param_s prm;
  logic [3:0][31:0]        eff;
  logic [17:0]             q[$];
  logic [17:0]             e;
  int                      fail_count, cmp_count, cyc;
  drive_parameter_holding_regs uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .reg_ack_o(ack), .reg_err_o(err), .ext_freq_valid_i(fv), .ext_freq_i(fq),
    .ext_freq_filt_o(filt), .params_o(prm), .ramp_time_eff_o(eff));
  net_master m (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .data_o(wd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic b);
    q.push_back({!w, b, d});
    m.xfer(w, a, d);
  endtask
  task automatic smp(input logic [15:0] v);
    @(posedge clk_i);
    #1 {fv, fq} = {1'b1, v};
    @(posedge clk_i);
    #1 fv = 1'b0;
  endtask
  task automatic results();
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk_i) if (ack === 1'b1 && q.size() > 0) begin
    e = q.pop_front();
    `CHK("err", e[16], err)
    if (e[17]) `CHK("rdata", e[15:0], rdata)
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {reset_n_i, en, fv, fq, rnd} = {3'b010, 16'h0000, 16'h9574};
    repeat (8) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    `CHK("reset", drive_param_pkg::PARAM_RESET, prm)
    acc(0, 16'h101A, 16'h0002, 0);
    for (int i = 0; i < 5; i++) for (int v = 0; v < 12; v++) acc(1, SEL_A[i], 16'(v), !SEL_OK[i][v]);
    acc(0, 16'h1019, 16'h000A, 0);
    acc(0, 16'h101D, 16'h0005, 0);
    acc(1, 16'h1014, 16'h0004, 0);
    acc(1, 16'h1015, 16'h93E0, 0);
    `CHK("ramp", 32'h0004_93E0, prm.ramp_time[0])
    acc(1, 16'h1015, 16'h93E1, 1);
    acc(0, 16'h1015, 16'h93E0, 0);
    acc(0, 16'h1014, 16'h0004, 0);
    acc(1, 16'h1503, 16'h0000, 0);
    acc(1, 16'h1504, 16'h0000, 1);
    acc(1, 16'h1502, 16'h2715, 0);
    `CHK("eff2", 32'h0000_2710, eff[2])
    rnd = lfsr(rnd);
    acc(1, 16'h1017, rnd, 0);
    `CHK("eff1", {16'h0000, (rnd >= 16'h2710) ? rnd - rnd % 16'h000A : rnd}, eff[1])
    acc(1, 16'h101C, 16'h0191, 1);
    acc(1, 16'h101C, 16'h0190, 0);
    acc(1, 16'h101B, 16'h001D, 1);
    acc(1, 16'h101B, 16'h0190, 0);
    acc(1, 16'h101C, 16'h018F, 1);
    acc(1, 16'h150C, 16'h0033, 1);
    acc(1, 16'h150D, 16'h0031, 1);
    acc(1, 16'h1020, 16'h0FA1, 1);
    acc(1, 16'h1022, 16'h0FA0, 0);
    acc(1, 16'h1024, 16'h0065, 1);
    acc(1, 16'h1023, 16'h0064, 0);
    acc(0, 16'h101E, 16'h0000, 1);
    acc(1, 16'h1026, 16'h0012, 1);
    acc(1, 16'h1026, 16'h0001, 0);
    rnd = lfsr(rnd);
    smp(rnd);
    `CHK("filt", rnd, filt)
    // a strobe while the enable is low must be ignored: no ack, nothing stored
    en = 1'b0;
    m.xfer(1, 16'h1018, 16'h0000);
    en = 1'b1;
    `CHK("freeze", drive_param_pkg::DIR_REV, prm.run_dir)
    reset_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    `CHK("reset2", drive_param_pkg::PARAM_RESET, prm)
    `CHK("filt0", 16'h0000, filt)
    acc(1, 16'h1026, 16'h0011, 0);
    smp(16'h0064);
    `CHK("db_first", 16'h0064, filt)
    smp(16'h0065);
    smp(16'h0066);
    `CHK("db_hold", 16'h0064, filt)
    smp(16'h006A);
    `CHK("db_up", 16'h0066, filt)
    smp(16'h0000);
    `CHK("db_down", 16'h0051, filt)
    `CHK("pending", 0, q.size())
    results();
  end
endmodule // testbench
`default_nettype wire
